// File: bench/host_model.sv
// host side model: drives the configuration select and lock pins
// assumes the bench calls pins() from its main process
module host_model (
  input  wire logic clk_sys,
  output logic      config_select_n,
  output logic      pll_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // pin driver
  // ********************
  initial begin
    config_select_n = 1'b1;
    pll_locked = 1'b0;
  end
  // change just after an edge; both pins are async to the block anyway
  task automatic pins(input logic cfg_n, input logic lk);
    @(posedge clk_sys);
    #1;
    config_select_n = cfg_n;
    pll_locked = lk;
  endtask
endmodule

// File: bench/mode_timer_monitor.sv
// checker: port timing of the mode transition timer
// assumes the state and phase codes of the shared header
`include "mode_timer_regs.vh"
module mode_timer_monitor (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       req,
  input wire logic [2:0] target,
  input wire logic       config_select_n,
  input wire logic [2:0] state_ff,
  input wire logic       busy_ff,
  input wire logic       done_ff,
  input wire logic [2:0] phase_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a request counts only while idle, a busy one is dropped
  wire logic acc = req && !busy_ff;
  property p_done_pulse; done_ff |=> !done_ff; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("long done");
  property p_busy_end; $fell(busy_ff) |-> done_ff; endproperty
  a_busy_end: assert property (p_busy_end) else $error("no done");
  property p_refuse;
    acc && state_ff == `ST_OFF && target == `ST_TX |=>
      !busy_ff && state_ff == `ST_OFF;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad pair taken");
  property p_sb_rx;
    acc && state_ff == `ST_STANDBY && target == `ST_RX |=> phase_ff == `PH_XTAL;
  endproperty
  a_sb_rx: assert property (p_sb_rx) else $error("no startup");
  property p_sb_cfg;
    acc && state_ff == `ST_STANDBY && target == `ST_CONFIG |=>
      phase_ff == `PH_XTAL;
  endproperty
  a_sb_cfg: assert property (p_sb_cfg) else $error("no startup");
  property p_rx_off;
    acc && state_ff == `ST_RX && target == `ST_OFF |=> phase_ff == `PH_ROFF;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("no on-to-off");
  // leaving config never restarts the oscillator
  property p_cfg_phase;
    state_ff == `ST_CONFIG |-> phase_ff != `PH_XTAL && phase_ff != `PH_ROFF;
  endproperty
  a_cfg_phase: assert property (p_cfg_phase) else $error("bad phase");
  property p_drop_rx;
    $fell(config_select_n) && state_ff == `ST_RX && !busy_ff |->
      ##[1:8] state_ff == `ST_CONFIG;
  endproperty
  a_drop_rx: assert property (p_drop_rx) else $error("slow drop");
  property p_drop_tx;
    $fell(config_select_n) && state_ff == `ST_TX && !busy_ff |->
      ##[1:8] state_ff == `ST_CONFIG;
  endproperty
  a_drop_tx: assert property (p_drop_tx) else $error("slow drop");
endmodule

bind mode_transition_timer mode_timer_monitor mode_timer_monitor_i (.*);

// File: bench/testbench.sv
// bench: mode requests and pin drops, judging states, phases and lengths
// assumes the shared header; phase counts are shortened to 5..9 cycles
`include "mode_timer_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic            clk_sys = 1'b0;
  logic            reset_n = 1'b0;
  logic            req = 1'b0;
  logic      [2:0] target = 3'h0;
  wire logic       config_select_n;
  wire logic       pll_locked;
  wire logic       busy_ff;
  wire logic       done_ff;
  wire logic [2:0] state_ff;
  wire logic [2:0] phase_ff;
  int              err_count = 0;
  int              total_checks = 0;
  always #4 clk_sys = ~clk_sys;
  mode_transition_timer mode_transition_timer_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .req(req), .target(target),
    .config_select_n(config_select_n), .pll_locked(pll_locked),
    .xtal_cnt(24'h000005), .lock_short_cnt(24'h000006),
    .lock_full_cnt(24'h000007), .pre_cnt(24'h000008),
    .roff_cnt(24'h000009), .state_ff(state_ff), .busy_ff(busy_ff),
    .done_ff(done_ff), .phase_ff(phase_ff));
  host_model host_model_i (.clk_sys(clk_sys),
    .config_select_n(config_select_n), .pll_locked(pll_locked));
  // ********************
  // shared tasks
  // ********************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic pulse(input logic [2:0] tgt);
    @(posedge clk_sys);
    #1;
    req = 1'b1;
    target = tgt;
    @(posedge clk_sys);
    #1;
    req = 1'b0;
  endtask
  // bounded wait for done, noting every phase passed through
  task automatic wait_done(input int lim, output int n, output logic [4:0] m);
    n = 0;
    m = 5'h00;
    while (done_ff !== 1'b1) begin
      if (phase_ff !== 3'h0) m[phase_ff] = 1'b1;
      if (n == lim) begin
        err_count++;
        $display("Error at %0t: timeout", $time);
        print_verdict();
      end
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  // one transition: phases seen match the mask, length from len to len + 8 cycles
  task automatic go(input logic [2:0] tgt, input logic [4:0] mask, int len);
    int n;
    logic [4:0] m;
    pulse(tgt);
    wait_done(300, n, m);
    check(8'(state_ff), 8'(tgt), "state");
    check(8'(m), 8'(mask), "phases");
    check(8'(n >= len && n <= len + 8), 8'h01, "length");
  endtask
  // config select low: lock level settles first so it is recorded
  task automatic drop(input logic lk);
    int n;
    logic [4:0] m;
    host_model_i.pins(1'b1, lk);
    repeat (6) @(posedge clk_sys);
    host_model_i.pins(1'b0, lk);
    wait_done(12, n, m);
    check(8'(state_ff), 8'(`ST_CONFIG), "drop state");
    check(8'(m), 8'h00, "drop phases");
    host_model_i.pins(1'b1, lk);
    repeat (6) @(posedge clk_sys);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_refuse();
    pulse(`ST_TX);
    repeat (3) @(posedge clk_sys);
    check(8'(busy_ff), 8'h00, "refused busy");
    check(8'(state_ff), 8'(`ST_OFF), "refused state");
    $display("test refuse finished");
  endtask
  task automatic t_off();
    go(`ST_RX, 5'h0e, 20);
    go(`ST_OFF, 5'h10, 9);
    $display("test off finished");
  endtask
  task automatic t_standby();
    go(`ST_RX, 5'h0e, 20);
    go(`ST_STANDBY, 5'h10, 9);
    go(`ST_RX, 5'h0e, 20);
    $display("test standby finished");
  endtask
  task automatic t_rx_cfg();
    drop(1'b1);
    go(`ST_RX, 5'h08, 8);
    $display("test rx config finished");
  endtask
  task automatic t_tx_cfg();
    go(`ST_STANDBY, 5'h10, 9);
    go(`ST_CONFIG, 5'h02, 5);
    go(`ST_TX, 5'h04, 7);
    drop(1'b0);
    go(`ST_RX, 5'h0c, 14);
    // locked before config: tx must land with no phase at all
    drop(1'b1);
    go(`ST_TX, 5'h00, 0);
    $display("test tx config finished");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_refuse();
    t_off();
    t_standby();
    t_rx_cfg();
    t_tx_cfg();
    print_verdict();
  end
endmodule

// File: hdl/mode_transition_timer.v
// mode transition timer: holds the operating state and times each requested change, except config to tx when locked before config
// assumes the mode logic raises req for one cycle with a legal target;
// config_select_n and pll_locked come from outside and are synchronised
`include "mode_timer_regs.vh"

module mode_transition_timer (
  input  wire              clk_sys,
  input  wire              reset_n,
  input  wire              req,
  input  wire [2:0]        target,
  input  wire              config_select_n,
  input  wire              pll_locked,
  input  wire [`CNT_W-1:0] xtal_cnt,
  input  wire [`CNT_W-1:0] lock_short_cnt,
  input  wire [`CNT_W-1:0] lock_full_cnt,
  input  wire [`CNT_W-1:0] pre_cnt,
  input  wire [`CNT_W-1:0] roff_cnt,
  output reg  [2:0]        state_ff,
  output reg               busy_ff,
  output reg               done_ff,
  output reg  [2:0]        phase_ff
);

  // *******************************************
  // input synchronisers
  // *******************************************
  // three stages; a change counts once stages two and three agree
  reg [2:0] cfg_sync_ff;
  reg [2:0] lock_sync_ff;
  reg       cfg_n_ff;
  reg       lock_ff;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_sync_ff  <= 3'h7;
      lock_sync_ff <= 3'h0;
      cfg_n_ff     <= 1'b1;
      lock_ff      <= 1'b0;
    end else begin
      cfg_sync_ff  <= {cfg_sync_ff[1:0], config_select_n};
      lock_sync_ff <= {lock_sync_ff[1:0], pll_locked};
      if (cfg_sync_ff[1] == cfg_sync_ff[2])
        cfg_n_ff <= cfg_sync_ff[2];
      if (lock_sync_ff[1] == lock_sync_ff[2])
        lock_ff <= lock_sync_ff[2];
    end
  end

  // *******************************************
  // transition bookkeeping
  // *******************************************
  reg  [2:0]        goal_ff;
  reg  [1:0]        lock_sel_ff;
  reg  [1:0]        saved_lock_ff;
  reg               load_ff;
  reg  [`CNT_W-1:0] load_val_ff;
  wire              cnt_done;

  reg  [2:0]        nxt_phase;
  reg  [`CNT_W-1:0] nxt_val;
  reg  [1:0]        nxt_lock;

  // first phase of a requested change, from current state and goal
  always @* begin
    nxt_phase = `PH_IDLE;
    nxt_val   = {`CNT_W{1'b0}};
    nxt_lock  = `LOCK_FULL;
    case (state_ff)
      `ST_STANDBY: begin
        if (target == `ST_CONFIG || target == `ST_RX) begin
          nxt_phase = `PH_XTAL;
          nxt_val   = xtal_cnt;
        end
      end
      `ST_OFF: begin
        if (target == `ST_RX) begin
          nxt_phase = `PH_XTAL;
          nxt_val   = xtal_cnt;
        end
      end
      `ST_CONFIG: begin
        if (target == `ST_RX || target == `ST_TX) begin
          nxt_lock = saved_lock_ff;
          if (saved_lock_ff == `LOCK_NONE && target == `ST_RX) begin
            nxt_phase = `PH_PRE;
            nxt_val   = pre_cnt;
          end else if (saved_lock_ff != `LOCK_NONE) begin
            nxt_phase = `PH_LOCK;
            nxt_val   = (saved_lock_ff == `LOCK_SHORT) ? lock_short_cnt
                        : lock_full_cnt;
          end
        end
      end
      `ST_RX: begin
        if (target == `ST_STANDBY || target == `ST_OFF) begin
          nxt_phase = `PH_ROFF;
          nxt_val   = roff_cnt;
        end
      end
      default: begin
        nxt_phase = `PH_IDLE;
      end
    endcase
  end

  // *******************************************
  // sequencer
  // *******************************************
  // the config-select drop wins over any timing in flight from rx or tx
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff      <= `ST_OFF;
      goal_ff       <= `ST_OFF;
      phase_ff      <= `PH_IDLE;
      busy_ff       <= 1'b0;
      done_ff       <= 1'b0;
      load_ff       <= 1'b0;
      load_val_ff   <= {`CNT_W{1'b0}};
      lock_sel_ff   <= `LOCK_FULL;
      saved_lock_ff <= `LOCK_FULL;
    end else begin
      done_ff <= 1'b0;
      load_ff <= 1'b0;
      if (!cfg_n_ff && (state_ff == `ST_RX || state_ff == `ST_TX)) begin
        // lock status is caught as configuration is entered
        saved_lock_ff <= lock_ff ? `LOCK_NONE : `LOCK_SHORT;
        state_ff      <= `ST_CONFIG;
        phase_ff      <= `PH_IDLE;
        busy_ff       <= 1'b0;
        done_ff       <= 1'b1;
      end else if (!busy_ff) begin
        // locked before config: tx needs no settling, so it lands at once
        if (req && state_ff == `ST_CONFIG && target == `ST_TX &&
            saved_lock_ff == `LOCK_NONE) begin
          state_ff <= `ST_TX;
          done_ff  <= 1'b1;
        end else if (req && nxt_phase != `PH_IDLE) begin
          goal_ff     <= target;
          phase_ff    <= nxt_phase;
          lock_sel_ff <= nxt_lock;
          load_val_ff <= nxt_val;
          load_ff     <= 1'b1;
          busy_ff     <= 1'b1;
          if (state_ff == `ST_STANDBY || state_ff == `ST_OFF)
            saved_lock_ff <= `LOCK_FULL;
        end
      end else if (cnt_done && !load_ff) begin
        // a done beside a fresh load is stale, left by a phase cut by a drop
        // advance to the next phase listed for this change only
        case (phase_ff)
          `PH_XTAL: begin
            if (goal_ff == `ST_RX) begin
              phase_ff    <= `PH_LOCK;
              load_val_ff <= lock_full_cnt;
              load_ff     <= 1'b1;
            end else begin
              state_ff <= goal_ff;
              phase_ff <= `PH_IDLE;
              busy_ff  <= 1'b0;
              done_ff  <= 1'b1;
            end
          end
          `PH_LOCK: begin
            if (goal_ff == `ST_RX) begin
              phase_ff    <= `PH_PRE;
              load_val_ff <= pre_cnt;
              load_ff     <= 1'b1;
            end else begin
              state_ff <= goal_ff;
              phase_ff <= `PH_IDLE;
              busy_ff  <= 1'b0;
              done_ff  <= 1'b1;
            end
          end
          default: begin
            state_ff <= goal_ff;
            phase_ff <= `PH_IDLE;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b1;
          end
        endcase
      end
    end
  end

  // *******************************************
  // shared phase counter
  // *******************************************
  // one counter serves all phases since they never overlap
  phase_counter u_cnt (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .load     (load_ff),
    .load_val (load_val_ff),
    .done_ff  (cnt_done)
  );

endmodule

// File: hdl/phase_counter.v
// down-counter for one delay phase of the transition timer
// assumes the caller loads it with a nonzero count and waits for done
`include "mode_timer_regs.vh"

module phase_counter (
  input  wire              clk_sys,
  input  wire              reset_n,
  input  wire              load,
  input  wire [`CNT_W-1:0] load_val,
  output reg               done_ff
);

  reg [`CNT_W-1:0] cnt_ff;
  reg              run_ff;

  // *******************************************
  // counter
  // *******************************************
  // done pulses one cycle when the loaded count has run out
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_ff  <= {`CNT_W{1'b0}};
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (load) begin
        cnt_ff <= (load_val == {`CNT_W{1'b0}}) ? {`CNT_W{1'b0}}
                  : load_val - {{(`CNT_W-1){1'b0}}, 1'b1};
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (cnt_ff <= {{(`CNT_W-1){1'b0}}, 1'b1}) begin
          run_ff  <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// File: pkg/mode_timer_regs.vh
// constants for the mode transition timer: state codes, phase codes, counts
// assumes a 125 MHz system clock; counts are reloadable by input ports
`ifndef MODE_TIMER_REGS_VH
`define MODE_TIMER_REGS_VH

// *******************************************
// operating states
// *******************************************
`define ST_OFF      3'h0
`define ST_STANDBY  3'h1
`define ST_CONFIG   3'h2
`define ST_RX       3'h3
`define ST_TX       3'h4

// *******************************************
// delay phases
// *******************************************
`define PH_IDLE     3'h0
`define PH_XTAL     3'h1
`define PH_LOCK     3'h2
`define PH_PRE      3'h3
`define PH_ROFF     3'h4

// lock choice codes
`define LOCK_NONE   2'h0
`define LOCK_SHORT  2'h1
`define LOCK_FULL   2'h2

// *******************************************
// timing: times in ns and cycles at 8 ns
// *******************************************
`define CLK_PERIOD_NS 8
`define CNT_W         24
`define XTAL_NS       600000
`define LOCK_FULL_NS  50000
`define LOCK_SHORT_NS 30000
`define PRE_NS        208000
`define ROFF_NS       100000
`define XTAL_CYC      ((`XTAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_FULL_CYC ((`LOCK_FULL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_SHORT_CYC ((`LOCK_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRE_CYC       ((`PRE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROFF_CYC      ((`ROFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif
